// ---- hdl/ssp_pkg.sv ----
// Purpose: shared types and constants of the synchronous serial port
// Assumes: one 100 MHz system clock
// Notes:   all widths and counts of the port are named here
package ssp_pkg;
	localparam int SSP_WIDTH = 16;
	localparam int SSP_DEPTH = 8;
	localparam int CLK_MHZ   = 100;
	// receive idle time before a time-out is flagged
	localparam int TIMEOUT_NS  = 10240;
	localparam int TIMEOUT_CYC = TIMEOUT_NS * CLK_MHZ / 1000;
	// service levels of the fifos
	localparam int TX_SERVICE_LEVEL = 4;
	localparam int RX_SERVICE_LEVEL = 4;
	// interrupt source positions
	localparam int IRQ_TX  = 0;
	localparam int IRQ_RX  = 1;
	localparam int IRQ_TMO = 2;
	localparam int IRQ_OVR = 3;
	localparam int IRQ_N   = 4;
	// frame constants
	localparam logic [4:0] CMD_DATA_START = 5'h09;
	localparam logic [4:0] CMD_EXTRA_BITS = 5'h0A;
	localparam logic [3:0] SIZE_TOP       = 4'hF;
	localparam logic [1:0] TI_SETUP_HALF  = 2'h2;
	localparam logic [1:0] SPI_SETUP_HALF = 2'h1;
	localparam logic [6:0] PRE_HALF_MIN   = 7'h01;

	typedef enum logic [1:0] {SSP_FMT_TI, SSP_FMT_SPI, SSP_FMT_CMD} ssp_fmt_type;

	// configuration bits
	typedef struct packed {
		logic        enable;
		logic        master;
		logic        loopback;
		ssp_fmt_type fmt;
		logic        clock_polarity_sel;
		logic        clock_phase_sel;
		logic [3:0]  size;
		logic [7:0]  prescale_divisor;
		logic [7:0]  serial_rate_field;
	} ssp_cfg_type;

	// pins seen from outside
	typedef struct packed {
		logic serial_bit_clock;
		logic frame_select_line;
		logic serial_in_line;
	} ssp_pin_in_type;

	typedef struct packed {
		logic serial_bit_clock;
		logic sclk_oe_n;
		logic frame_select_line;
		logic fss_oe_n;
		logic serial_out_line;
		logic sdo_oe_n;
	} ssp_pin_out_type;
endpackage

// ---- hdl/ssp_core.sv ----
// Purpose: synchronous serial port, master or slave, three frame formats
// Assumes: pins synchronous to clk_in; config held stable during frames
// Notes:   cpu side is a push port, a pop port and plain status bits
// Operation
// - First divide the system clock by an even prescale of 2 to 254.
// - Then divide by one plus the rate field, giving 1 to 256.
// - Master clock at most half sysclk; slave clock at most sysclk over 12.
// - Transmit fifo holds eight 16-bit words, filled by cpu, drained by shifter.
// - Receive fifo holds eight 16-bit words until the cpu pops them.
// - Incoming bits are caught in a shift register, then loaded in parallel.
// - Slave with empty fifo resends the eighth latest word, else zero.
// - Transmit fifo emptying can raise an interrupt or a dma request.
// - Fifos serve dma per direction, enabled by dma control bits.
// - Four interrupt conditions are ORed onto one request line.
// - Each source has a mask bit; one enables it onto the output.
// - Raw and masked state of every source can be read.
// - Word length 4 to 16 bits, sent most significant bit first.
// - Serial clock stays at its idle level except during transfers.
// - Time-out flags when receive data waits while the clock stays idle.
// - Spi and command formats hold an active low frame select all frame.
// - Frame-pulse format pulses select one period; drive rising, sample falling.
// - Frame-pulse idle holds clock and select low, data output floats.
// - Frame-pulse start pulses select, loads shifter, msb follows on rising edge.
// - Frame-pulse received word enters fifo on first rising edge after lsb.
// - Command format sends 8 bits ignoring input, waits one clock, reads back.
// - Spi polarity low idles clock low, high idles it high.
// - Spi phase low samples on first transition, high on the second.
`timescale 1ns/100ps
module ssp_core #(
	parameter int DEPTH       = ssp_pkg::SSP_DEPTH,
	parameter int TIMEOUT_CYC = ssp_pkg::TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   reset_in,
	// configuration and masks
	input  wire ssp_pkg::ssp_cfg_type   cfg_in,
	input  wire logic [3:0]             irq_mask_in,
	input  wire logic [1:0]             dma_enable_in,
	input  wire logic [1:0]             irq_clear_in,
	// transmit push port
	input  wire logic                   wr_valid_in,
	input  wire logic [15:0]            wr_data_in,
	output logic                        wr_ready_out,
	// receive pop port
	input  wire logic                   rd_pop_in,
	output logic [15:0]                 rd_data_out,
	output logic                        rd_valid_out,
	// status
	output logic [3:0]                  irq_raw_out,
	output logic [3:0]                  irq_masked_out,
	output logic                        irq_out,
	output logic                        tx_dma_req_out,
	output logic                        rx_dma_req_out,
	output logic                        busy_out,
	// serial pins
	input  wire ssp_pkg::ssp_pin_in_type pin_in,
	output ssp_pkg::ssp_pin_out_type    pin_out
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("ssp_core: DEPTH must be a power of two");
	end
	if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 65535) begin : g_chk_tmo
		$error("ssp_core: TIMEOUT_CYC out of range");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_XFER, ST_END} ssp_state_type;

	ssp_state_type           st_reg;
	logic [15:0]             tx_mem [DEPTH];
	logic [15:0]             rx_mem [DEPTH];
	logic [AW:0]             tx_wr_reg, tx_rd_reg, rx_wr_reg, rx_rd_reg;
	logic [AW:0]             tx_count, rx_count;
	logic                    tx_empty, tx_full, rx_empty, rx_full;
	logic                    tx_push, tx_pop, rx_push, rx_pop;
	logic [15:0]             tx_shift_reg, rx_shift_reg, rx_word;
	logic [4:0]              bit_idx_reg, total_bits;
	logic [5:0]              hcnt_reg;
	logic [6:0]              pre_cnt_reg, pre_half;
	logic [7:0]              rate_cnt_reg;
	logic                    half_tick, sclk_reg, sclk_prev_reg, fss_prev_reg;
	logic                    is_ti, is_cmd, idle_lvl, samp_lead, din;
	logic                    edge_ev, lead_ev, trail_ev, samp_ev, shift_ev, last_samp;
	logic                    m_start, s_start, load, s_abort, ti_pend_reg;
	logic [15:0]             tmo_cnt_reg;
	logic                    tmo_reg, ovr_reg;
	ssp_pkg::ssp_pin_out_type pins_next;

	// format decode
	assign is_ti     = cfg_in.fmt == ssp_pkg::SSP_FMT_TI;
	assign is_cmd    = cfg_in.fmt == ssp_pkg::SSP_FMT_CMD;
	assign idle_lvl  = (cfg_in.fmt == ssp_pkg::SSP_FMT_SPI) & cfg_in.clock_polarity_sel;
	assign samp_lead = is_cmd | (!is_ti & !cfg_in.clock_phase_sel);
	assign total_bits = is_cmd ? 5'(cfg_in.size) + ssp_pkg::CMD_EXTRA_BITS
	                           : 5'(cfg_in.size) + 5'h01;
	assign din = cfg_in.loopback ? tx_shift_reg[15] : pin_in.serial_in_line;
	// a push on the last sample must take that sample's bit along
	assign rx_word = is_ti ? rx_shift_reg : {rx_shift_reg[14:0], din};

	// fifo bookkeeping
	assign tx_count = tx_wr_reg - tx_rd_reg;
	assign rx_count = rx_wr_reg - rx_rd_reg;
	assign tx_empty = tx_count == '0;
	assign rx_empty = rx_count == '0;
	assign tx_full  = tx_count == (AW+1)'(DEPTH);
	assign rx_full  = rx_count == (AW+1)'(DEPTH);
	assign wr_ready_out = !tx_full;
	assign tx_push  = wr_valid_in & !tx_full;
	assign rx_pop   = rd_pop_in & !rx_empty;
	assign rd_valid_out = !rx_empty;
	assign rd_data_out  = rx_mem[rx_rd_reg[AW-1:0]];

	// transmit fifo; storage clears at reset so an early replay sends zero
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				tx_mem[i] <= 16'h0000;
			end
			tx_wr_reg <= '0;
			tx_rd_reg <= '0;
		end else begin
			if (tx_push) begin
				tx_mem[tx_wr_reg[AW-1:0]] <= wr_data_in;
				tx_wr_reg <= tx_wr_reg + 1'b1;
			end
			if (tx_pop) begin
				tx_rd_reg <= tx_rd_reg + 1'b1;
			end
		end
	end

	// receive fifo; a word arriving when full is dropped
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rx_wr_reg <= '0;
			rx_rd_reg <= '0;
		end else begin
			if (rx_push && !rx_full) begin
				rx_mem[rx_wr_reg[AW-1:0]] <= rx_word;
				rx_wr_reg <= rx_wr_reg + 1'b1;
			end
			if (rx_pop) begin
				rx_rd_reg <= rx_rd_reg + 1'b1;
			end
		end
	end

	// bit-rate divider: half period = prescale/2 * (1 + rate) cycles
	assign pre_half  = (cfg_in.prescale_divisor[7:1] == 7'h00) ? ssp_pkg::PRE_HALF_MIN
	                 : cfg_in.prescale_divisor[7:1];
	assign half_tick = cfg_in.master && st_reg != ST_IDLE && pre_cnt_reg == pre_half - 1'b1
	                 && rate_cnt_reg == cfg_in.serial_rate_field;

	always_ff @(posedge clk_in) begin
		if (reset_in || st_reg == ST_IDLE || !cfg_in.master) begin
			pre_cnt_reg  <= 7'h00;
			rate_cnt_reg <= 8'h00;
		end else if (pre_cnt_reg == pre_half - 1'b1) begin
			pre_cnt_reg  <= 7'h00;
			rate_cnt_reg <= (rate_cnt_reg == cfg_in.serial_rate_field) ? 8'h00
			              : rate_cnt_reg + 1'b1;
		end else begin
			pre_cnt_reg <= pre_cnt_reg + 1'b1;
		end
	end

	// clock edges: own divider as master, sampled pin as slave
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sclk_prev_reg <= 1'b0;
			fss_prev_reg  <= 1'b1;
		end else begin
			sclk_prev_reg <= pin_in.serial_bit_clock;
			fss_prev_reg  <= pin_in.frame_select_line;
		end
	end

	assign edge_ev = cfg_in.master ? (st_reg == ST_XFER && half_tick)
	               : (cfg_in.enable && pin_in.serial_bit_clock != sclk_prev_reg);
	assign lead_ev  = edge_ev && ((cfg_in.master ? sclk_reg : sclk_prev_reg) == idle_lvl);
	assign trail_ev = edge_ev && !lead_ev;
	assign samp_ev  = st_reg == ST_XFER && (samp_lead ? lead_ev : trail_ev);
	assign shift_ev = st_reg == ST_XFER && (samp_lead ? trail_ev : lead_ev)
	                && (samp_lead || bit_idx_reg != 5'h00);
	assign last_samp = samp_ev && bit_idx_reg == total_bits - 1'b1;

	// frame start; slave spi with phase high runs on select level
	assign m_start = cfg_in.enable && cfg_in.master && st_reg == ST_IDLE && !tx_empty;
	assign s_start = cfg_in.enable && !cfg_in.master && st_reg == ST_IDLE
	               && ((cfg_in.fmt == ssp_pkg::SSP_FMT_SPI && cfg_in.clock_phase_sel)
	               ? !pin_in.frame_select_line
	               : (fss_prev_reg && !pin_in.frame_select_line));
	assign s_abort = !cfg_in.master && !is_ti && pin_in.frame_select_line;
	assign load    = m_start | s_start;
	assign tx_pop  = load & !tx_empty;

	// frame sequencer
	always_ff @(posedge clk_in) begin
		if (reset_in || !cfg_in.enable) begin
			st_reg   <= ST_IDLE;
			hcnt_reg <= 6'h00;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					hcnt_reg <= 6'h00;
					if (m_start) begin
						st_reg <= ST_SETUP;
					end else if (s_start) begin
						st_reg <= ST_XFER;
					end
				end
				ST_SETUP: begin
					if (half_tick) begin
						if (hcnt_reg == 6'(is_ti ? ssp_pkg::TI_SETUP_HALF
						                           : ssp_pkg::SPI_SETUP_HALF) - 1'b1) begin
							st_reg   <= ST_XFER;
							hcnt_reg <= 6'h00;
						end else begin
							hcnt_reg <= hcnt_reg + 1'b1;
						end
					end
				end
				ST_XFER: begin
					if (!cfg_in.master) begin
						if (last_samp || s_abort) begin
							st_reg <= ST_IDLE;
						end
					end else if (half_tick) begin
						if (hcnt_reg == {total_bits - 1'b1, 1'b1}) begin // last of 2*bits halves
							st_reg <= ST_END;
						end else begin
							hcnt_reg <= hcnt_reg + 1'b1;
						end
					end
				end
				ST_END: begin
					if (half_tick) begin
						st_reg <= ST_IDLE;
					end
				end
				default: begin
					st_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// master serial clock; toggles only in the pulse period and the data bits
	always_ff @(posedge clk_in) begin
		if (reset_in || st_reg == ST_IDLE) begin
			sclk_reg <= reset_in ? 1'b0 : idle_lvl;
		end else if (half_tick && (st_reg == ST_XFER || (st_reg == ST_SETUP && is_ti))) begin
			sclk_reg <= !sclk_reg;
		end
	end

	// transmit shifter, word left aligned so the msb leaves first
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tx_shift_reg <= 16'h0000;
		end else if (load) begin
			tx_shift_reg <= is_cmd ? {tx_mem[tx_rd_reg[AW-1:0]][7:0], 8'h00}
			              : tx_mem[tx_rd_reg[AW-1:0]] << (ssp_pkg::SIZE_TOP - cfg_in.size);
		end else if (shift_ev) begin
			tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
		end
	end

	// receive shifter and bit counter; command phase ignores input
	always_ff @(posedge clk_in) begin
		if (reset_in || load) begin
			rx_shift_reg <= 16'h0000;
			bit_idx_reg  <= 5'h00;
		end else if (samp_ev) begin
			bit_idx_reg <= bit_idx_reg + 1'b1;
			if (!is_cmd || bit_idx_reg >= ssp_pkg::CMD_DATA_START) begin
				rx_shift_reg <= {rx_shift_reg[14:0], din};
			end
		end
	end

	// frame-pulse words wait for the next rising edge before the fifo
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ti_pend_reg <= 1'b0;
		end else if (last_samp && is_ti) begin
			ti_pend_reg <= 1'b1;
		end else if (rx_push) begin
			ti_pend_reg <= 1'b0;
		end
	end
	assign rx_push = (last_samp && !is_ti)
	               || (ti_pend_reg && (lead_ev || (st_reg == ST_END && half_tick)));

	// time-out watch: data waiting and no clock activity
	always_ff @(posedge clk_in) begin
		if (reset_in || rx_empty || edge_ev || rx_pop) begin
			tmo_cnt_reg <= 16'h0000;
		end else if (tmo_cnt_reg != 16'(TIMEOUT_CYC - 1)) begin
			tmo_cnt_reg <= tmo_cnt_reg + 1'b1;
		end
	end

	// sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tmo_reg <= 1'b0;
			ovr_reg <= 1'b0;
		end else begin
			tmo_reg <= (tmo_cnt_reg == 16'(TIMEOUT_CYC - 2)) | (tmo_reg & !irq_clear_in[0]);
			ovr_reg <= (rx_push & rx_full) | (ovr_reg & !irq_clear_in[1]);
		end
	end

	// interrupt and dma status
	always_comb begin
		irq_raw_out = 4'h0;
		irq_raw_out[ssp_pkg::IRQ_TX]  = tx_count <= (AW+1)'(ssp_pkg::TX_SERVICE_LEVEL);
		irq_raw_out[ssp_pkg::IRQ_RX]  = rx_count >= (AW+1)'(ssp_pkg::RX_SERVICE_LEVEL);
		irq_raw_out[ssp_pkg::IRQ_TMO] = tmo_reg;
		irq_raw_out[ssp_pkg::IRQ_OVR] = ovr_reg;
	end
	assign irq_masked_out = irq_raw_out & irq_mask_in;
	assign irq_out        = |irq_masked_out;
	assign tx_dma_req_out = dma_enable_in[0] & irq_raw_out[ssp_pkg::IRQ_TX];
	assign rx_dma_req_out = dma_enable_in[1] & !rx_empty;
	assign busy_out       = st_reg != ST_IDLE || !tx_empty;

	// pin drive; frame-pulse idle floats data, spi select active low
	always_comb begin
		pins_next.serial_bit_clock  = cfg_in.master ? sclk_reg : idle_lvl;
		pins_next.sclk_oe_n         = !(cfg_in.enable && cfg_in.master);
		pins_next.frame_select_line = (st_reg == ST_IDLE) ? !is_ti
		                            : (is_ti ? st_reg == ST_SETUP : 1'b0);
		pins_next.fss_oe_n          = !(cfg_in.enable && cfg_in.master);
		pins_next.serial_out_line   = (st_reg == ST_IDLE) ? 1'b0 : tx_shift_reg[15];
		pins_next.sdo_oe_n          = cfg_in.master ? !(cfg_in.enable && !(is_ti && st_reg == ST_IDLE))
		                            : st_reg != ST_XFER;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pin_out <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		end else begin
			pin_out <= pins_next;
		end
	end

	// checks
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	logic [15:0] gap_reg;
	always_ff @(posedge clk_in) begin
		if (reset_in || half_tick || st_reg == ST_IDLE) begin
			gap_reg <= 16'h0000;
		end else begin
			gap_reg <= gap_reg + 1'b1;
		end
	end

	a_half_period: assert property (half_tick && $stable(cfg_in) |->
		gap_reg + 16'h0001 == 16'(pre_half) * (16'(cfg_in.serial_rate_field) + 16'h0001))
		else $error("half period length wrong");
	a_tx_bound: assert property (tx_count <= (AW+1)'(DEPTH) && !(tx_full && tx_push))
		else $error("tx fifo over bound");
	a_rx_store: assert property (rx_push && !rx_full && !rx_pop |=>
		rx_count == $past(rx_count) + 1'b1)
		else $error("rx word not stored");
	a_ovr_flag: assert property (rx_push && rx_full |=> irq_raw_out[ssp_pkg::IRQ_OVR]
		&& rx_count == $past(rx_count) - (AW+1)'($past(rx_pop)))
		else $error("overrun not flagged");
	a_irq_gate: assert property (irq_out |-> (irq_raw_out & irq_mask_in) != 4'h0)
		else $error("irq without enabled source");
	a_tmo_cause: assert property ($rose(tmo_reg) |-> $past(!rx_empty) && $past(!edge_ev))
		else $error("time-out without waiting data");
	a_sclk_idle: assert property (cfg_in.master && st_reg == ST_IDLE && $stable(cfg_in)
		##1 cfg_in.master && st_reg == ST_IDLE |=> pin_out.serial_bit_clock == $past(idle_lvl, 2))
		else $error("serial clock not idle");
	a_spi_select: assert property (cfg_in.master && !is_ti && st_reg == ST_XFER
		&& $stable(cfg_in) |=> !pin_out.frame_select_line && !pin_out.fss_oe_n)
		else $error("select not low in frame");
	a_ti_idle: assert property (cfg_in.master && is_ti && st_reg == ST_IDLE && $stable(cfg_in)
		|=> pin_out.sdo_oe_n && !pin_out.frame_select_line)
		else $error("frame-pulse idle pins wrong");
	a_cmd_ignore: assert property (is_cmd && samp_ev && bit_idx_reg < ssp_pkg::CMD_DATA_START
		|=> rx_shift_reg == $past(rx_shift_reg))
		else $error("command phase captured input");
	a_replay_keep: assert property (s_start && tx_empty |=> tx_rd_reg == $past(tx_rd_reg))
		else $error("replay moved read pointer");

	c_spi_frame: cover property (cfg_in.master && !is_ti && !is_cmd && st_reg == ST_END ##1
		st_reg == ST_IDLE);
	c_ti_push: cover property (is_ti && ti_pend_reg ##1 rx_push);
	c_cmd_frame: cover property (is_cmd && last_samp);
	c_overrun: cover property (rx_push && rx_full);
endmodule

// ---- bench/ssp_spi_partner.sv ----
// Purpose: behavioural spi slave facing the serial port in master mode
// Assumes: pins sampled on clk_in, sclk far slower than clk_in
// Notes:   returns reply_in msb first, collects what the master sends
`timescale 1ns/100ps
module ssp_spi_partner (
	// clock
	input  wire logic        clk_in,
	// mode and data
	input  wire logic        cpol_in,
	input  wire logic        cpha_in,
	input  wire logic [3:0]  size_in,
	input  wire logic [15:0] reply_in,
	output logic [15:0]      got_out,
	// serial pins
	input  wire logic        sclk_in,
	input  wire logic        fss_in,
	input  wire logic        sdo_in,
	output logic             sdi_out
);
	logic        sdi_q  = 1'b0;
	logic        sclk_d = 1'b0;
	logic        fss_d  = 1'b1;
	logic [15:0] sh     = 16'h0000;
	logic [15:0] got_q  = 16'h0000;
	logic        lead;
	assign sdi_out = sdi_q;
	assign got_out = got_q;
	// slave shifter; a deselected line toggles so no stale bit is read
	always @(posedge clk_in) begin
		lead = (sclk_d == cpol_in);
		sclk_d <= sclk_in;
		fss_d  <= fss_in;
		if (fss_in) begin
			sdi_q <= ~sdi_q;
		end else if (fss_d) begin
			sh    <= reply_in << (4'hF - size_in);
			got_q <= 16'h0000;
			if (!cpha_in) begin
				sdi_q <= reply_in[size_in];
			end
		end else if (sclk_in != sclk_d) begin
			if (lead ^ cpha_in) begin
				got_q <= {got_q[14:0], sdo_in};
			end else if (cpha_in) begin
				sdi_q <= sh[15];
				sh    <= sh << 1;
			end else begin
				sdi_q <= sh[14];
				sh    <= sh << 1;
			end
		end
	end
endmodule

// ---- bench/ssp_core_test.sv ----
// Purpose: self-checking bench of the serial port as master in all three formats, then as spi slave
// Assumes: half period of 6 clocks from prescale 4 and rate 2
// Notes:   loopback used to fill the receive fifo and force overrun
`timescale 1ns/100ps
module ssp_core_test;
	logic                     clk_in = 1'b0;
	logic                     reset_in = 1'b1;
	ssp_pkg::ssp_cfg_type     cfg;
	logic [3:0]               irq_mask = 4'h0;
	logic [1:0]               dma_en = 2'h3;
	logic [1:0]               irq_clr = 2'h0;
	logic                     wr_valid = 1'b0;
	logic [15:0]              wr_data = 16'h0000;
	logic                     wr_ready, rd_pop = 1'b0, rd_valid, irq, tx_dma, rx_dma, busy, sdi;
	logic [15:0]              rd_data, reply, got;
	logic [3:0]               irq_raw, irq_masked;
	ssp_pkg::ssp_pin_in_type  pin_in;
	ssp_pkg::ssp_pin_out_type pin_out;
	int                       num_errors = 0;
	int                       total_checks = 0;
	int                       cycles = 0;
	int                       gap = 0;
	int                       min_gap = 255;
	int                       idle_toggles = 0;
	logic                     sclk_q = 1'b0;
	logic                     sclk_drv = 1'b0;
	logic                     fss_drv = 1'b1;
	assign pin_in = {sclk_drv, fss_drv, sdi};
	ssp_core #(.TIMEOUT_CYC(40)) i_ssp_core (.clk_in(clk_in), .reset_in(reset_in), .cfg_in(cfg),
		.irq_mask_in(irq_mask), .dma_enable_in(dma_en), .irq_clear_in(irq_clr),
		.wr_valid_in(wr_valid), .wr_data_in(wr_data), .wr_ready_out(wr_ready),
		.rd_pop_in(rd_pop), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
		.irq_raw_out(irq_raw), .irq_masked_out(irq_masked), .irq_out(irq),
		.tx_dma_req_out(tx_dma), .rx_dma_req_out(rx_dma), .busy_out(busy),
		.pin_in(pin_in), .pin_out(pin_out));
	ssp_spi_partner i_ssp_spi_partner (.clk_in(clk_in), .cpol_in(cfg.clock_polarity_sel),
		.cpha_in(cfg.clock_phase_sel), .size_in(cfg.size), .reply_in(reply), .got_out(got),
		.sclk_in(pin_out.serial_bit_clock), .fss_in(pin_out.frame_select_line),
		.sdo_in(pin_out.serial_out_line), .sdi_out(sdi));
	// 100 MHz clock
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	// clock edge watch and run limit
	always @(posedge clk_in) begin
		cycles++;
		if (pin_out.serial_bit_clock !== sclk_q) begin
			if (gap < min_gap) min_gap = gap;
			gap = 1;
			if (pin_out.frame_select_line) idle_toggles++;
		end else gap++;
		sclk_q = pin_out.serial_bit_clock;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// push one word, holding valid until ready is seen at an edge
	task automatic push(input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_in) #1;
		wr_valid = 1'b1;
		wr_data  = d;
		while (!wr_ready && n < 2000) begin
			@(posedge clk_in) #1;
			n++;
		end
		check("push ready", {15'h0, wr_ready}, 16'h0001);
		@(posedge clk_in) #1;
		wr_valid = 1'b0;
	endtask
	// pop the head word after comparing it
	task automatic pop(input logic [15:0] exp);
		check("rx valid", {15'h0, rd_valid}, 16'h0001);
		check("rx word", rd_data, exp);
		rd_pop = 1'b1;
		@(posedge clk_in) #1;
		rd_pop = 1'b0;
		@(posedge clk_in) #1;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge clk_in);
		#1;
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge clk_in) #1;
			n++;
		end
		check("idle reached", {15'h0, busy}, 16'h0000);
		repeat (8) @(posedge clk_in);
		#1;
	endtask
	// main sequence
	initial begin
		cfg = '{enable:1'b0, master:1'b1, loopback:1'b0, fmt:ssp_pkg::SSP_FMT_SPI,
			clock_polarity_sel:1'b0, clock_phase_sel:1'b0, size:4'h7,
			prescale_divisor:8'h04, serial_rate_field:8'h02};
		reply = 16'h0000;
		repeat (4) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		check("ready after reset", {15'h0, wr_ready}, 16'h0001);
		check("raw after reset", {12'h0, irq_raw}, 16'h0001);
		check("clock oe after reset", {15'h0, pin_out.sclk_oe_n}, 16'h0001);
		$display("test reset done");
		// four clock modes against the slave model
		cfg.enable = 1'b1;
		for (int m = 0; m < 4; m++) begin
			cfg.clock_polarity_sel = m[1];
			cfg.clock_phase_sel    = m[0];
			reply = 16'h00A5 ^ 16'(m);
			repeat (8) @(posedge clk_in);
			#1;
			idle_toggles = 0;
			min_gap = 255;
			push(16'hF05A + 16'(m));
			wait_idle();
			check("slave got", got, 16'h005A + 16'(m));
			pop(reply);
			check("idle clock", {15'h0, pin_out.serial_bit_clock}, 16'(m[1]));
			check("idle select", {15'h0, pin_out.frame_select_line}, 16'h0001);
			check("toggles outside frame", 16'(idle_toggles), 16'h0000);
			check("half period", 16'(min_gap), 16'h0006);
		end
		$display("test modes done");
		// fill while disabled, then loop back through the shifter
		cfg.enable = 1'b0;
		cfg.loopback = 1'b1;
		for (int i = 0; i < 8; i++) push(16'h0010 + 16'(i));
		check("full refuses", {15'h0, wr_ready}, 16'h0000);
		check("tx dma full", {15'h0, tx_dma}, 16'h0000);
		cfg.enable = 1'b1;
		wait_idle();
		check("tx dma empty", {15'h0, tx_dma}, 16'h0001);
		check("rx dma", {15'h0, rx_dma}, 16'h0001);
		check("rx service", {15'h0, irq_raw[ssp_pkg::IRQ_RX]}, 16'h0001);
		push(16'h00EE);
		wait_idle();
		check("overrun raw", {15'h0, irq_raw[ssp_pkg::IRQ_OVR]}, 16'h0001);
		check("irq masked off", {15'h0, irq}, 16'h0000);
		irq_mask = 4'h8;
		#1;
		check("masked state", {12'h0, irq_masked}, 16'h0008);
		check("irq on", {15'h0, irq}, 16'h0001);
		irq_mask = 4'h0;
		for (int i = 0; i < 8; i++) pop(16'h0010 + 16'(i));
		check("drained", {15'h0, rd_valid}, 16'h0000);
		irq_clr = 2'h3;
		@(posedge clk_in) #1;
		irq_clr = 2'h0;
		check("overrun cleared", {15'h0, irq_raw[ssp_pkg::IRQ_OVR]}, 16'h0000);
		check("time-out cleared", {15'h0, irq_raw[ssp_pkg::IRQ_TMO]}, 16'h0000);
		$display("test loopback done");
		// receive data left waiting on an idle clock
		push(16'h0077);
		wait_idle();
		check("no early timeout", {15'h0, irq_raw[ssp_pkg::IRQ_TMO]}, 16'h0000);
		repeat (40) @(posedge clk_in);
		#1;
		check("timeout raw", {15'h0, irq_raw[ssp_pkg::IRQ_TMO]}, 16'h0001);
		pop(16'h0077);
		$display("test timeout done");
		// frame-pulse word and command word through the loopback
		cfg.fmt = ssp_pkg::SSP_FMT_TI;
		push(16'h00C3);
		wait_idle();
		pop(16'h00C3);
		cfg.fmt = ssp_pkg::SSP_FMT_CMD;
		push(16'h00FF);
		wait_idle();
		pop(16'h0000);
		$display("test formats done");
		// slave spi with empty fifo, clock from the bench, replay looped back
		cfg.fmt                = ssp_pkg::SSP_FMT_SPI;
		cfg.master             = 1'b0;
		cfg.clock_polarity_sel = 1'b0;
		cfg.clock_phase_sel    = 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
		fss_drv = 1'b0;
		repeat (16) begin
			repeat (12) @(posedge clk_in);
			#1;
			sclk_drv = ~sclk_drv;
		end
		repeat (12) @(posedge clk_in);
		#1;
		fss_drv = 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		// eighth most recent of the sixteen pushes so far
		pop(16'h0014);
		$display("test slave done");
		end_sim();
	end
endmodule
